// ### hw/cci_pkg.sv
// constants shared by the calibration command interpreter and its output fifo
// assumes one 50 MHz clock; command words arrive already deserialised
package cci_pkg;

    // ********************************************************
    // clock and command window timing
    // ********************************************************
    localparam int CLK_MHZ = 50;
    localparam int CMD_WINDOW_US = 10000;
    localparam int CMD_WINDOW_FAST_US = 3500;
    // longest times: whole cycles, rounded down
    localparam int CMD_WINDOW_CYC = CMD_WINDOW_US * CLK_MHZ;
    localparam int CMD_WINDOW_FAST_CYC = CMD_WINDOW_FAST_US * CLK_MHZ;
    localparam int WIN_CNT_W = 19;

    // ********************************************************
    // command bytes and fixed data bytes
    // ********************************************************
    localparam logic [7:0] CMD_TRIM = 8'h30;
    localparam logic [7:0] CMD_MODE = 8'h40;
    localparam logic [7:0] DAT_NORMAL = 8'h00;
    localparam logic [7:0] DAT_RAW = 8'h10;
    localparam logic [7:0] CMD_ENTRY = 8'h50;
    localparam logic [7:0] DAT_ENTRY = 8'h90;
    localparam logic [7:0] CMD_SECOND_ORDER = 8'h60;
    localparam logic [7:0] CMD_SETTLE = 8'h70;
    localparam logic [7:0] CMD_GAINB_HI = 8'h80;
    localparam logic [7:0] CMD_GAINB_LO = 8'h90;
    localparam logic [7:0] CMD_OFFB_HI = 8'ha0;
    localparam logic [7:0] CMD_OFFB_LO = 8'hb0;
    localparam logic [7:0] CMD_GAINT = 8'hc0;
    localparam logic [7:0] CMD_OFFT = 8'hd0;
    localparam logic [7:0] CMD_TCO = 8'he0;
    localparam logic [7:0] CMD_UNLOCK = 8'he8;
    localparam logic [7:0] CMD_TCG = 8'hf0;
    localparam logic [7:0] CMD_CLIP_HI = 8'h08;
    localparam logic [7:0] CMD_CLIP_LO = 8'h18;
    localparam logic [7:0] CMD_SERIAL0 = 8'h28;
    localparam logic [7:0] CMD_SERIAL1 = 8'h38;
    localparam logic [7:0] CMD_SERIAL2 = 8'h48;

    // ********************************************************
    // trim selector nibbles and lock field codes
    // ********************************************************
    localparam logic [3:0] SEL_FACTORY = 4'h0;
    localparam logic [3:0] SEL_LOCK = 4'hd;
    localparam logic [3:0] SEL_DIAG = 4'he;
    localparam logic [2:0] LOCK_INT = 3'h3;
    localparam logic [2:0] LOCK_EXT = 3'h6;
    localparam int LOCK_EXT_BIT = 2;
    localparam int FAST_START_BIT = 2;

    // ********************************************************
    // widths and reset values
    // ********************************************************
    localparam int BRIDGE_W = 14;
    localparam int TEMP_W = 11;
    localparam logic [2:0] LOCK_RST = 3'h0;
    localparam logic [2:0] DIAG_RST = 3'h0;
    localparam logic [2:0] FACTORY_RST = 3'h0;
    localparam logic [1:0] EMIT_FULL = 2'h3;
    localparam int FIFO_DEPTH = 16;
    localparam int BYTE_W = 8;

    typedef enum logic [1:0] {
        MODE_WINDOW = 2'b00,
        MODE_COMMAND = 2'b01,
        MODE_NORMAL = 2'b10,
        MODE_RAW = 2'b11
    } cci_mode_e;

endpackage : cci_pkg

// ### hw/cci_fifo.sv
// byte fifo between the measurement emitter and the output serialiser
// assumes both sides on one clock; reader may stall at will
`timescale 1ns/1ps
module cci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
    } cci_fifo_s;

    cci_fifo_s st_ff;
    cci_fifo_s nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic doWrite;
    logic doRead;

    assign inReady = (st_ff.count != (AW+1)'(DEPTH));
    assign outValid = (st_ff.count != '0);
    assign outData = mem[st_ff.rdPtr];
    assign doWrite = inValid & inReady;
    assign doRead = outValid & outReady;

    always_comb begin
        nxt_st = st_ff;
        if (doWrite) begin
            nxt_st.wrPtr = (st_ff.wrPtr == AW'(DEPTH - 1)) ? '0 : st_ff.wrPtr + 1'b1;
        end
        if (doRead) begin
            nxt_st.rdPtr = (st_ff.rdPtr == AW'(DEPTH - 1)) ? '0 : st_ff.rdPtr + 1'b1;
        end
        if (doWrite & ~doRead) begin
            nxt_st.count = st_ff.count + 1'b1;
        end else if (doRead & ~doWrite) begin
            nxt_st.count = st_ff.count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // storage needs no reset: only words below the count are ever read
    always_ff @(posedge ref_clk) begin
        if (doWrite) begin
            mem[st_ff.wrPtr] <= inData;
        end
    end

    property p_fifo_bound;
        @(posedge ref_clk) disable iff (reset)
        st_ff.count <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count beyond depth");

endmodule : cci_fifo

// ### hw/cci_command_interpreter.sv
// calibration command interpreter: decodes command/data word pairs,
// holds calibration settings, and streams measurement bytes out
// assumes cmdWord/cmdValid and sample ports come from logic on ref_clk
`timescale 1ns/1ps
module cci_command_interpreter
    import cci_pkg::*;
#(
    parameter int WINDOW_CYC = CMD_WINDOW_CYC,
    parameter int WINDOW_FAST_CYC = CMD_WINDOW_FAST_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cmdValid,
    input wire logic [15:0] cmdWord,
    input wire logic sampleValid,
    input wire logic [BRIDGE_W-1:0] rawBridge,
    input wire logic [TEMP_W-1:0] rawTemp,
    input wire logic [BRIDGE_W-1:0] corrBridge,
    input wire logic [TEMP_W-1:0] corrTemp,
    output logic outValid,
    input wire logic outReady,
    output logic [7:0] outData,
    output logic [1:0] opMode,
    output logic sampleMissed,
    output logic cmdRefused,
    output logic [7:0] second_order_coef,
    output logic [7:0] settling_time_setting,
    output logic [14:0] gainBridge,
    output logic [13:0] offsetBridge,
    output logic [7:0] gainTemp,
    output logic [7:0] offsetTemp,
    output logic [7:0] tempCoefOffset,
    output logic [7:0] tempCoefGain,
    output logic [6:0] clipUpper,
    output logic [6:0] clipLower,
    output logic [7:0] customer_serial_byte0,
    output logic [7:0] customer_serial_byte1,
    output logic [7:0] customer_serial_byte2,
    output logic [2:0] factoryCfg,
    output logic [2:0] diagCfg,
    output logic [2:0] lockTempCfg,
    output logic eepromLocked,
    output logic externalDiodeTemp,
    output logic lockSuspended,
    output logic trimStrobe,
    output logic [3:0] trimSelect,
    output logic [3:0] trimValue
);

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        cci_mode_e mode;
        logic [WIN_CNT_W-1:0] winCnt;
        logic [7:0] secondOrder;
        logic [7:0] settle;
        logic [14:0] gainB;
        logic [13:0] offB;
        logic [7:0] gainT;
        logic [7:0] offT;
        logic [7:0] tco;
        logic [7:0] tcg;
        logic [6:0] clipHi;
        logic [6:0] clipLo;
        logic [23:0] serial;
        logic [2:0] factory;
        logic [2:0] diag;
        logic [2:0] lockCfg;
        logic locked;
        logic lockOff;
        logic trimStb;
        logic [3:0] trimSel;
        logic [3:0] trimVal;
        logic refused;
        logic missed;
        logic [1:0] emitCnt;
        logic [7:0] byte0;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } cci_state_s;

    cci_state_s st_ff;
    cci_state_s nxt_st;

    function automatic logic isLocked(input logic [2:0] field);
        isLocked = (field == LOCK_INT) || (field == LOCK_EXT);
    endfunction : isLocked

    // ********************************************************
    // command decode
    // ********************************************************
    logic [7:0] cmdByte;
    logic [7:0] datByte;
    logic isEntry;
    logic inCommand;
    logic winOpen;
    logic canWrite;
    logic fifoReady;
    logic streaming;
    logic [WIN_CNT_W-1:0] winLimit;

    assign cmdByte = cmdWord[15:8];
    assign datByte = cmdWord[7:0];
    assign isEntry = (cmdByte == CMD_ENTRY) && (datByte == DAT_ENTRY);
    assign inCommand = (st_ff.mode == MODE_COMMAND);
    // fast startup bit shortens the window in which entry is honoured
    assign winLimit = st_ff.factory[FAST_START_BIT] ? WIN_CNT_W'(WINDOW_FAST_CYC)
                                                  : WIN_CNT_W'(WINDOW_CYC);
    assign winOpen = (st_ff.mode == MODE_WINDOW) && (st_ff.winCnt < winLimit);
    assign canWrite = ~st_ff.locked | st_ff.lockOff;
    assign streaming = (st_ff.mode == MODE_NORMAL) || (st_ff.mode == MODE_RAW);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.trimStb = 1'b0;
        nxt_st.refused = 1'b0;
        nxt_st.missed = 1'b0;

        // startup window: entry inside it, normal operation once it runs out
        if (st_ff.mode == MODE_WINDOW) begin
            if (winOpen) begin
                nxt_st.winCnt = st_ff.winCnt + 1'b1;
            end else begin
                nxt_st.mode = MODE_NORMAL;
            end
        end

        if (cmdValid) begin
            if (isEntry && (winOpen || inCommand)) begin
                nxt_st.mode = MODE_COMMAND;
            end else if (!inCommand) begin
                nxt_st.refused = 1'b1;
            end else if (cmdByte == CMD_MODE) begin
                if (datByte == DAT_NORMAL) begin
                    nxt_st.mode = MODE_NORMAL;
                end else if (datByte == DAT_RAW) begin
                    nxt_st.mode = MODE_RAW;
                end else begin
                    nxt_st.refused = 1'b1;
                end
            end else if (cmdByte == CMD_UNLOCK) begin
                nxt_st.lockOff = 1'b1;
            end else if (!canWrite) begin
                nxt_st.refused = 1'b1;
            end else begin
                case (cmdByte)
                    CMD_TRIM: begin
                        case (datByte[7:4])
                            SEL_FACTORY: nxt_st.factory = datByte[2:0];
                            SEL_LOCK: nxt_st.lockCfg = datByte[2:0];
                            SEL_DIAG: nxt_st.diag = datByte[2:0];
                            default: begin
                                nxt_st.trimStb = 1'b1;
                                nxt_st.trimSel = datByte[7:4];
                                nxt_st.trimVal = datByte[3:0];
                            end
                        endcase
                    end
                    CMD_SECOND_ORDER: nxt_st.secondOrder = datByte;
                    CMD_SETTLE: nxt_st.settle = {1'b0, datByte[6:0]};
                    CMD_GAINB_HI: nxt_st.gainB[14:8] = datByte[6:0];
                    CMD_GAINB_LO: nxt_st.gainB[7:0] = datByte;
                    CMD_OFFB_HI: nxt_st.offB[13:8] = datByte[5:0];
                    CMD_OFFB_LO: nxt_st.offB[7:0] = datByte;
                    CMD_GAINT: nxt_st.gainT = datByte;
                    CMD_OFFT: nxt_st.offT = datByte;
                    CMD_TCO: nxt_st.tco = datByte;
                    CMD_TCG: nxt_st.tcg = datByte;
                    CMD_CLIP_HI: nxt_st.clipHi = datByte[6:0];
                    CMD_CLIP_LO: nxt_st.clipLo = datByte[6:0];
                    CMD_SERIAL0: nxt_st.serial[7:0] = datByte;
                    CMD_SERIAL1: nxt_st.serial[15:8] = datByte;
                    CMD_SERIAL2: nxt_st.serial[23:16] = datByte;
                    default: nxt_st.refused = 1'b1;
                endcase
            end
        end

        nxt_st.locked = isLocked(nxt_st.lockCfg);

        // ********************************************************
        // measurement emitter: three bytes per sample
        // ********************************************************
        if ((st_ff.emitCnt != 2'h0) && fifoReady) begin
            nxt_st.emitCnt = st_ff.emitCnt - 1'b1;
            nxt_st.byte0 = st_ff.byte1;
            nxt_st.byte1 = st_ff.byte2;
        end
        // a sample that lands while the emitter still holds unsent bytes is dropped, not
        // merged, so the master never sees a torn triple
        if (sampleValid && streaming) begin
            if (st_ff.emitCnt == 2'h0) begin
                nxt_st.emitCnt = EMIT_FULL;
                if (st_ff.mode == MODE_RAW) begin
                    nxt_st.byte0 = {2'b00, rawBridge[13:8]};
                    nxt_st.byte1 = rawBridge[7:0];
                    nxt_st.byte2 = rawTemp[7:0];
                end else begin
                    nxt_st.byte0 = {2'b00, corrBridge[13:8]};
                    nxt_st.byte1 = corrBridge[7:0];
                    nxt_st.byte2 = corrTemp[7:0];
                end
            end else begin
                nxt_st.missed = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '{mode: MODE_WINDOW, factory: FACTORY_RST, diag: DIAG_RST,
                       lockCfg: LOCK_RST, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ********************************************************
    // output fifo
    // ********************************************************
    cci_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .inValid(st_ff.emitCnt != 2'h0),
        .inReady(fifoReady),
        .inData(st_ff.byte0),
        .outValid(outValid),
        .outReady(outReady),
        .outData(outData)
    );

    assign opMode = st_ff.mode;
    assign sampleMissed = st_ff.missed;
    assign cmdRefused = st_ff.refused;
    assign second_order_coef = st_ff.secondOrder;
    assign settling_time_setting = st_ff.settle;
    assign gainBridge = st_ff.gainB;
    assign offsetBridge = st_ff.offB;
    assign gainTemp = st_ff.gainT;
    assign offsetTemp = st_ff.offT;
    assign tempCoefOffset = st_ff.tco;
    assign tempCoefGain = st_ff.tcg;
    assign clipUpper = st_ff.clipHi;
    assign clipLower = st_ff.clipLo;
    assign customer_serial_byte0 = st_ff.serial[7:0];
    assign customer_serial_byte1 = st_ff.serial[15:8];
    assign customer_serial_byte2 = st_ff.serial[23:16];
    assign factoryCfg = st_ff.factory;
    assign diagCfg = st_ff.diag;
    assign lockTempCfg = st_ff.lockCfg;
    assign eepromLocked = st_ff.locked;
    assign externalDiodeTemp = st_ff.lockCfg[LOCK_EXT_BIT];
    assign lockSuspended = st_ff.lockOff;
    assign trimStrobe = st_ff.trimStb;
    assign trimSelect = st_ff.trimSel;
    assign trimValue = st_ff.trimVal;

    // ********************************************************
    // checks
    // ********************************************************
    property p_entry;
        @(posedge ref_clk) disable iff (reset)
        (cmdValid && isEntry && (winOpen || inCommand)) |=> (st_ff.mode == MODE_COMMAND);
    endproperty
    a_entry: assert property (p_entry) else $error("entry pair did not enter command mode");

    property p_normal;
        @(posedge ref_clk) disable iff (reset)
        (cmdValid && inCommand && cmdWord == {CMD_MODE, DAT_NORMAL}) |=> (opMode == MODE_NORMAL);
    endproperty
    a_normal: assert property (p_normal) else $error("4000 did not start normal mode");

    property p_raw;
        @(posedge ref_clk) disable iff (reset)
        (cmdValid && inCommand && cmdWord == {CMD_MODE, DAT_RAW}) |=> (opMode == MODE_RAW);
    endproperty
    a_raw: assert property (p_raw) else $error("4010 did not start raw mode");

    property p_second_order;
        @(posedge ref_clk) disable iff (reset)
        (cmdValid && inCommand && canWrite && cmdByte == CMD_SECOND_ORDER)
            |=> (second_order_coef == $past(datByte));
    endproperty
    a_second_order: assert property (p_second_order) else $error("second order coefficient not stored");

    property p_gain_hi;
        @(posedge ref_clk) disable iff (reset)
        (cmdValid && inCommand && canWrite && cmdByte == CMD_GAINB_HI)
            |=> (gainBridge[14:8] == $past(datByte[6:0])) && $stable(gainBridge[7:0]);
    endproperty
    a_gain_hi: assert property (p_gain_hi) else $error("gain upper half wrong");

    property p_unlock_sticks;
        @(posedge ref_clk) disable iff (reset)
        lockSuspended |=> lockSuspended;
    endproperty
    a_unlock_sticks: assert property (p_unlock_sticks) else $error("lock suspend lost");

    property p_lock_code;
        @(posedge ref_clk) disable iff (reset)
        eepromLocked == (lockTempCfg == LOCK_INT || lockTempCfg == LOCK_EXT);
    endproperty
    a_lock_code: assert property (p_lock_code) else $error("lock flag disagrees with field");

    property p_locked_blocks;
        @(posedge ref_clk) disable iff (reset)
        (cmdValid && inCommand && eepromLocked && !lockSuspended && cmdByte == CMD_SERIAL0)
            |=> $stable(customer_serial_byte0) && cmdRefused;
    endproperty
    a_locked_blocks: assert property (p_locked_blocks) else $error("locked write went through");

    property p_window_end;
        @(posedge ref_clk) disable iff (reset)
        (st_ff.mode == MODE_WINDOW && st_ff.winCnt >= winLimit && !cmdValid)
            |=> (opMode == MODE_NORMAL);
    endproperty
    a_window_end: assert property (p_window_end) else $error("window did not close");

    property p_raw_order;
        @(posedge ref_clk) disable iff (reset)
        (sampleValid && st_ff.mode == MODE_RAW && st_ff.emitCnt == 2'h0)
            |=> (st_ff.byte0 == {2'b00, $past(rawBridge[13:8])})
                && (st_ff.byte2 == $past(rawTemp[7:0])) && (st_ff.emitCnt == EMIT_FULL);
    endproperty
    a_raw_order: assert property (p_raw_order) else $error("raw triple malformed");

endmodule : cci_command_interpreter

// ### testbench/cci_master_model.sv
// calibration master model: sends command words and drains output bytes
// assumes ref_clk from the bench; stall holds outReady low
`timescale 1ns/1ps
module cci_master_model (
    input wire logic ref_clk,
    input wire logic stall,
    output logic cmdValid,
    output logic [15:0] cmdWord,
    input wire logic outValid,
    output logic outReady,
    input wire logic [7:0] outData
);
    logic [7:0] rxQ[$];
    logic slow = 1'b0;
    initial begin
        cmdValid = 1'b0;
        cmdWord = 16'h0000;
        outReady = 1'b0;
    end
    // command byte and data byte travel as one word
    task automatic send(input logic [15:0] w);
        @(posedge ref_clk);
        #1 cmdValid = 1'b1;
        cmdWord = w;
        @(posedge ref_clk);
        #1 cmdValid = 1'b0;
        // released word shows the inverted command, not the last command
        cmdWord = ~w;
    endtask : send
    // ready only every other cycle: a slow reader
    always @(posedge ref_clk) begin
        if (outValid && outReady) begin
            rxQ.push_back(outData);
        end
        slow <= ~slow;
        outReady <= #1 ~stall & slow;
    end
endmodule : cci_master_model

// ### testbench/calibration_command_interpreter_bench.sv
// self-checking bench: queue model of the output byte stream and settings
// assumes the design package and the master model are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failCount++; \
    $display("ERROR %0t mismatch got %h exp %h", $time, (a), (b)); end end
module calibration_command_interpreter_bench;
    import cci_pkg::*;
    logic ref_clk, reset, cmdValid, sampleValid, outValid, outReady, stall;
    logic [15:0] cmdWord;
    logic [13:0] rawBridge, corrBridge, offsetBridge;
    logic [14:0] gainBridge;
    logic [10:0] rawTemp, corrTemp;
    logic [7:0] outData, second_order_coef, settling_time_setting, gainTemp, offsetTemp;
    logic [7:0] tempCoefOffset, tempCoefGain, customer_serial_byte0;
    logic [7:0] customer_serial_byte1, customer_serial_byte2;
    logic [6:0] clipUpper, clipLower;
    logic [2:0] factoryCfg, diagCfg, lockTempCfg;
    logic [3:0] trimSelect, trimValue;
    logic [1:0] opMode;
    logic sampleMissed, cmdRefused, eepromLocked, externalDiodeTemp, lockSuspended, trimStrobe;
    logic [7:0] expQ[$];
    logic [7:0] dat [15];
    logic [7:0] cmdList [15] = '{8'h60, 8'h70, 8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc0, 8'hd0,
        8'he0, 8'hf0, 8'h08, 8'h18, 8'h28, 8'h38, 8'h48};
    logic [31:0] rnd = 32'd70911;
    int failCount = 0;
    int checked = 0;
    int cycles = 0;
    cci_command_interpreter #(.WINDOW_CYC(600), .WINDOW_FAST_CYC(20)) uut (
        .ref_clk(ref_clk), .reset(reset), .cmdValid(cmdValid), .cmdWord(cmdWord),
        .sampleValid(sampleValid), .rawBridge(rawBridge), .rawTemp(rawTemp),
        .corrBridge(corrBridge), .corrTemp(corrTemp), .outValid(outValid),
        .outReady(outReady), .outData(outData), .opMode(opMode),
        .sampleMissed(sampleMissed), .cmdRefused(cmdRefused),
        .second_order_coef(second_order_coef),
        .settling_time_setting(settling_time_setting),
        .gainBridge(gainBridge), .offsetBridge(offsetBridge), .gainTemp(gainTemp),
        .offsetTemp(offsetTemp), .tempCoefOffset(tempCoefOffset),
        .tempCoefGain(tempCoefGain), .clipUpper(clipUpper), .clipLower(clipLower),
        .customer_serial_byte0(customer_serial_byte0),
        .customer_serial_byte1(customer_serial_byte1),
        .customer_serial_byte2(customer_serial_byte2), .factoryCfg(factoryCfg),
        .diagCfg(diagCfg), .lockTempCfg(lockTempCfg), .eepromLocked(eepromLocked),
        .externalDiodeTemp(externalDiodeTemp), .lockSuspended(lockSuspended),
        .trimStrobe(trimStrobe), .trimSelect(trimSelect), .trimValue(trimValue));
    cci_master_model m (.ref_clk(ref_clk), .stall(stall), .cmdValid(cmdValid),
        .cmdWord(cmdWord), .outValid(outValid), .outReady(outReady), .outData(outData));
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    task automatic stopTest();
        $display("comparisons %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stopTest
    task automatic cmd(input logic [15:0] w, input logic refused);
        m.send(w);
        `CHK(cmdRefused, refused)
    endtask : cmd
    // mode 0 ignored, 1 raw, 2 corrected
    task automatic sample(input int mode, input logic miss);
        logic [13:0] b;
        logic [10:0] t;
        rnd = nxt(rnd);
        b = mode == 2 ? ~rnd[13:0] : rnd[13:0];
        t = mode == 2 ? ~rnd[26:16] : rnd[26:16];
        @(posedge ref_clk);
        #1 sampleValid = 1'b1;
        rawBridge = rnd[13:0];
        rawTemp = rnd[26:16];
        corrBridge = ~rnd[13:0];
        corrTemp = ~rnd[26:16];
        @(posedge ref_clk);
        #1 sampleValid = 1'b0;
        `CHK(sampleMissed, miss)
        if (mode != 0 && !miss) begin
            expQ.push_back({2'b00, b[13:8]});
            expQ.push_back(b[7:0]);
            expQ.push_back(t[7:0]);
        end
        repeat (6) @(posedge ref_clk);
    endtask : sample
    task automatic drain();
        int n;
        logic [7:0] g, e;
        n = 0;
        while (m.rxQ.size() < expQ.size() && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(m.rxQ.size(), expQ.size())
        while (expQ.size() > 0 && m.rxQ.size() > 0) begin
            g = m.rxQ.pop_front();
            e = expQ.pop_front();
            `CHK(g, e)
        end
        $display("stream test done");
    endtask : drain
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            stopTest();
        end
    end
    initial begin
        {reset, stall, sampleValid} = 3'b100;
        {rawBridge, rawTemp, corrBridge, corrTemp} = '0;
        repeat (12) @(posedge ref_clk);
        #1 reset = 1'b0;
        `CHK(opMode, 2'h0)
        cmd(16'h5090, 1'b0);
        `CHK(opMode, 2'h1)
        sample(0, 1'b0);
        for (int i = 0; i < 15; i++) begin
            rnd = nxt(rnd);
            dat[i] = rnd[7:0];
            // master keeps the unused upper data bits at zero, except bit 7 of the settling time data
            if (cmdList[i] == 8'h80 || cmdList[i] == 8'h08 || cmdList[i] == 8'h18) begin
                dat[i][7] = 1'b0;
            end
            if (cmdList[i] == 8'ha0) begin
                dat[i][7:6] = 2'b00;
            end
            cmd({cmdList[i], dat[i]}, 1'b0);
        end
        `CHK(second_order_coef, dat[0])
        `CHK(settling_time_setting, {1'b0, dat[1][6:0]})
        `CHK(gainBridge, {dat[2][6:0], dat[3]})
        `CHK(offsetBridge, {dat[4][5:0], dat[5]})
        `CHK({gainTemp, offsetTemp, tempCoefOffset, tempCoefGain},
            {dat[6], dat[7], dat[8], dat[9]})
        `CHK({clipUpper, clipLower}, {dat[10][6:0], dat[11][6:0]})
        `CHK({customer_serial_byte2, customer_serial_byte1, customer_serial_byte0},
            {dat[14], dat[13], dat[12]})
        cmd(16'h30e5, 1'b0);
        `CHK({diagCfg, trimStrobe}, {3'h5, 1'b0})
        cmd(16'h3015, 1'b0);
        `CHK({trimSelect, trimValue}, 8'h15)
        `CHK(trimStrobe, 1'b1)
        cmd(16'h3004, 1'b0);
        `CHK(factoryCfg, 3'h4)
        cmd(16'h30d6, 1'b0);
        cmd(16'h6011, 1'b1);
        cmd(16'h2811, 1'b1);
        `CHK(customer_serial_byte0, dat[12])
        cmd(16'he800, 1'b0);
        `CHK(lockSuspended, 1'b1)
        for (int v = 0; v < 8; v++) begin
            cmd({12'h30d, 1'b0, v[2:0]}, 1'b0);
            `CHK({eepromLocked, externalDiodeTemp, lockTempCfg},
                {v == 3 || v == 6, v[2], v[2:0]})
        end
        $display("program test done");
        cmd(16'h4022, 1'b1);
        cmd(16'h4010, 1'b0);
        `CHK(opMode, 2'h3)
        stall = 1'b1;
        for (int i = 0; i < 6; i++) sample(1, 1'b0); // first point
        sample(1, 1'b1);
        #1 stall = 1'b0;
        repeat (8) @(posedge ref_clk); // settle before the next point
        for (int i = 0; i < 10; i++) sample(1, 1'b0); // second point
        drain();
        // entry is only honoured inside the startup window or in command mode
        cmd(16'h5090, 1'b1);
        `CHK(opMode, 2'h3)
        #1 reset = 1'b1;
        #40 reset = 1'b0;
        `CHK(lockSuspended, 1'b0)
        cmd(16'h5090, 1'b0);
        cmd(16'h4000, 1'b0);
        `CHK(opMode, 2'h2)
        sample(2, 1'b0);
        drain();
        #1 reset = 1'b1;
        #40 reset = 1'b0;
        repeat (620) @(posedge ref_clk);
        cmd(16'h5090, 1'b1);
        `CHK(opMode, 2'h2)
        $display("window test done");
        stopTest();
    end
endmodule : calibration_command_interpreter_bench
